/* File: rtl/bst_pkg.sv */
`default_nettype none
package bst_pkg;

  // Controller states of the test access port.
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR,
    ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } bst_state_type;

  localparam int          CHAIN_LEN  = 158;
  localparam int          IR_LEN     = 3;
  localparam int          ID_LEN     = 32;
  localparam int          TMS_RESET_RISES = 5;

  // Instruction codes.
  localparam logic [2:0]  IR_EXTEST  = 3'h0;
  localparam logic [2:0]  IR_INTEST  = 3'h1;
  localparam logic [2:0]  IR_SAMPLE  = 3'h2;
  localparam logic [2:0]  IR_IDCODE  = 3'h3;
  localparam logic [2:0]  IR_BYPASS  = 3'h7;
  localparam logic [2:0]  IR_CAPTURE = 3'h1;

  // Cell values after reset, bit 157 nearest the serial input.
  localparam logic [157:0] CHAIN_INIT = {35'b00100_00_000_0_0_01_011_110_000_010_000_001_100, 123'h0};

  // Cells that watch a pin level (capture cells of inputs and two-way pins).
  localparam logic [157:0] IN_CELLS = {5'b11111, 2'b00, 3'b100, 1'b0, 1'b1, 2'b00, {16{3'b100}}, 2'b11,
    {2{3'b100}}, 16'h0000, {3{3'b100}}, 1'b1, 14'h0000, 3'b100, 14'h0000, {2{3'b100}}, 1'b1,
    {4{3'b100}}, 1'b0, 2'b11, 2'b00, 3'b100, 1'b1, 2'b00, 1'b0};

endpackage
`default_nettype wire

/* File: rtl/bst_tap_if.sv */
`timescale 1ns/100ps
`default_nettype none
// Carries the sampled test pins into the controller and its state back out.
interface bst_tap_if;
  import bst_pkg::*;
  logic          tck_rise;
  logic          tms;
  logic          trst_n;
  bst_state_type state;
  modport ctl  (input tck_rise, input tms, input trst_n, output state);
  modport user (output tck_rise, output tms, output trst_n, input state);
endinterface
`default_nettype wire

/* File: rtl/bst_tap_fsm.sv */
`timescale 1ns/100ps
`default_nettype none
module bst_tap_fsm (
  input  wire logic clk,
  input  wire logic rst_n,
  bst_tap_if.ctl    tap
);
  import bst_pkg::*;

  bst_state_type state_r;
  bst_state_type state_nxt;
  logic [2:0]    hi_cnt_r;
  logic [2:0]    hi_cnt_nxt;

  assign tap.state = state_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Sixteen-state walk, advanced on a rising test clock edge; a low test reset forces reset without one.
  always_comb begin
    state_nxt = state_r;
    if (!tap.trst_n) begin
      state_nxt = ST_RESET;
    end else if (tap.tck_rise) begin
      case (state_r)
        ST_RESET:    state_nxt = tap.tms ? ST_RESET   : ST_IDLE;
        ST_IDLE:     state_nxt = tap.tms ? ST_SEL_DR  : ST_IDLE;
        ST_SEL_DR:   state_nxt = tap.tms ? ST_SEL_IR  : ST_CAP_DR;
        ST_CAP_DR:   state_nxt = tap.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
        ST_SHIFT_DR: state_nxt = tap.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
        ST_EXIT1_DR: state_nxt = tap.tms ? ST_UPD_DR  : ST_PAUSE_DR;
        ST_PAUSE_DR: state_nxt = tap.tms ? ST_EXIT2_DR : ST_PAUSE_DR;
        ST_EXIT2_DR: state_nxt = tap.tms ? ST_UPD_DR  : ST_SHIFT_DR;
        ST_UPD_DR:   state_nxt = tap.tms ? ST_SEL_DR  : ST_IDLE;
        ST_SEL_IR:   state_nxt = tap.tms ? ST_RESET   : ST_CAP_IR;
        ST_CAP_IR:   state_nxt = tap.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
        ST_SHIFT_IR: state_nxt = tap.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
        ST_EXIT1_IR: state_nxt = tap.tms ? ST_UPD_IR  : ST_PAUSE_IR;
        ST_PAUSE_IR: state_nxt = tap.tms ? ST_EXIT2_IR : ST_PAUSE_IR;
        ST_EXIT2_IR: state_nxt = tap.tms ? ST_UPD_IR  : ST_SHIFT_IR;
        ST_UPD_IR:   state_nxt = tap.tms ? ST_SEL_DR  : ST_IDLE;
        default:     state_nxt = ST_RESET;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Helper count of consecutive rising edges with the mode select high.
  always_comb begin
    hi_cnt_nxt = hi_cnt_r;
    if (tap.tck_rise) begin
      hi_cnt_nxt = !tap.tms ? 3'h0 : (hi_cnt_r == 3'h7) ? hi_cnt_r : hi_cnt_r + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_cnt_r <= 3'h0;
    end else begin
      hi_cnt_r <= hi_cnt_nxt;
    end
  end

  // Five rises with the mode select high reach reset from any state.
  chk_tms_high_reset: assert property (@(posedge clk) disable iff (!rst_n)
    (hi_cnt_r >= 3'(TMS_RESET_RISES)) |-> (state_r == ST_RESET))
    else $error("Controller not in reset after five high mode-select edges.");

  // A low test reset forces the reset state on the next clock.
  chk_trst_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !tap.trst_n |=> (state_r == ST_RESET))
    else $error("Test reset did not hold the controller in reset.");

endmodule
`default_nettype wire

/* File: rtl/bst_top.sv */
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Boundary chain is one serial path of 158 cells from serial input to output.
// - Inputs use one cell, outputs two, two-way pins three cells.
// - Data bus bits seven and fifteen and some others use three cells.
// - All cells start at their constant value, also held on untested pin sides.
// - Tester shifts a three-bit instruction in, least significant bit first.
// - Codes 000 extest, 001 intest, 010 sample, 011 identify, others bypass.
// - Extest captures input pins and drives outputs from boundary values.
// - Extest shifts out captured vector while next shifts in, then updates outputs.
// - Capture of the instruction path loads code 001.
// - Sample takes a pin snapshot while the device runs normally.
// - Identify shifts out 32 bits: version, device code, maker code.
// - Test-logic-reset loads the identify instruction.
// - Bypass passes a bit through one single-stage register.
// - Sixteen-state standard controller steers the port.
// - Mode select held high returns the controller to reset.
// - Low test reset holds the controller in reset.
module bst_top #(
  parameter logic [3:0]  ID_VERSION = 4'h1,     // Arbitrary value.
  parameter logic [15:0] ID_DEVICE  = 16'h0A5C, // Arbitrary value.
  parameter logic [10:0] ID_MAKER   = 11'h155   // Arbitrary value.
) (
  input  wire logic                            MCLK,
  input  wire logic                            RST_N,
  input  wire logic                            TCK,
  input  wire logic                            TMS,
  input  wire logic                            TDI,
  input  wire logic                            TRST_N,
  input  wire logic [bst_pkg::CHAIN_LEN-1:0]   PAD_IN,
  input  wire logic [bst_pkg::CHAIN_LEN-1:0]   CORE_IN,
  output logic                                 TDO,
  output logic                                 TDO_OE,
  output logic [bst_pkg::CHAIN_LEN-1:0]        CELL_OUT,
  output logic                                 EXT_MODE,
  output logic                                 INT_MODE
);
  import bst_pkg::*;

  localparam logic [ID_LEN-1:0] ID_WORD = {ID_VERSION, ID_DEVICE, ID_MAKER, 1'b1};

  bst_tap_if tap ();

  logic [3:0]           sy1_r;
  logic [3:0]           sy2_r;
  logic                 tck_q_r;
  logic                 tck_fall;
  logic                 tdi_s;
  logic [CHAIN_LEN-1:0] pad_s1_r;
  logic [CHAIN_LEN-1:0] pad_s2_r;
  logic [IR_LEN-1:0]    ir_r;
  logic [IR_LEN-1:0]    ir_nxt;
  logic [IR_LEN-1:0]    ir_sh_r;
  logic [IR_LEN-1:0]    ir_sh_nxt;
  logic [CHAIN_LEN-1:0] bsr_r;
  logic [CHAIN_LEN-1:0] bsr_nxt;
  logic [CHAIN_LEN-1:0] upd_r;
  logic [CHAIN_LEN-1:0] upd_nxt;
  logic [CHAIN_LEN-1:0] cap_vec;
  logic [ID_LEN-1:0]    id_sh_r;
  logic [ID_LEN-1:0]    id_sh_nxt;
  logic                 bp_r;
  logic                 bp_nxt;
  logic                 tdo_nxt;
  logic                 oe_nxt;
  logic                 ext_nxt;
  logic                 int_nxt;
  logic                 dr_bit;
  logic                 in_shift;

  // Which data register a code selects; unknown codes fall back to bypass.
  function automatic logic [2:0] dr_sel(input logic [2:0] code);
    if (code == IR_EXTEST || code == IR_INTEST || code == IR_SAMPLE) begin
      dr_sel = IR_EXTEST;
    end else if (code == IR_IDCODE) begin
      dr_sel = IR_IDCODE;
    end else begin
      dr_sel = IR_BYPASS;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for the pins; the first stage feeds only the second.
  // The pad levels are synchronised too, since board lines move with no regard to MCLK.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sy1_r    <= 4'h8;
      sy2_r    <= 4'h8;
      tck_q_r  <= 1'b0;
      pad_s1_r <= '0;
      pad_s2_r <= '0;
    end else begin
      sy1_r    <= {TRST_N, TCK, TMS, TDI};
      sy2_r    <= sy1_r;
      tck_q_r  <= sy2_r[2];
      pad_s1_r <= PAD_IN;
      pad_s2_r <= pad_s1_r;
    end
  end

  // Edges are seen on the synchronised clock, so all four pins stay aligned.
  assign tap.tck_rise = sy2_r[2] & ~tck_q_r;
  assign tck_fall     = ~sy2_r[2] & tck_q_r;
  assign tap.tms      = sy2_r[1];
  assign tap.trst_n   = sy2_r[3];
  assign tdi_s        = sy2_r[0];

  bst_tap_fsm u_fsm (
    .clk   (MCLK),
    .rst_n (RST_N),
    .tap   (tap)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Instruction path.
  always_comb begin
    ir_nxt    = ir_r;
    ir_sh_nxt = ir_sh_r;
    if (tap.state == ST_RESET) begin
      ir_nxt = IR_IDCODE;
    end
    if (tap.tck_rise) begin
      case (tap.state)
        ST_CAP_IR:   ir_sh_nxt = IR_CAPTURE;
        ST_SHIFT_IR: ir_sh_nxt = {tdi_s, ir_sh_r[IR_LEN-1:1]};
        ST_UPD_IR:   ir_nxt = ir_sh_r;
        default:     ir_sh_nxt = ir_sh_r;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ir_r    <= IR_IDCODE;
      ir_sh_r <= IR_CAPTURE;
    end else begin
      ir_r    <= ir_nxt;
      ir_sh_r <= ir_sh_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Capture source per cell: pin cells watch the pads (extest, sample) or the update
  // latch (intest), drive cells watch what is driven (extest) or the core (intest, sample).
  always_comb begin
    if (ir_r == IR_EXTEST) begin
      cap_vec = (pad_s2_r & IN_CELLS) | (upd_r & ~IN_CELLS);
    end else if (ir_r == IR_INTEST) begin
      cap_vec = (upd_r & IN_CELLS) | (CORE_IN & ~IN_CELLS);
    end else begin
      cap_vec = (pad_s2_r & IN_CELLS) | (CORE_IN & ~IN_CELLS);
    end
  end

  // Data registers: boundary chain, its update latch, identification and bypass.
  always_comb begin
    bsr_nxt   = bsr_r;
    upd_nxt   = upd_r;
    id_sh_nxt = id_sh_r;
    bp_nxt    = bp_r;
    if (tap.state == ST_RESET) begin
      upd_nxt = CHAIN_INIT;
    end
    if (tap.tck_rise) begin
      case (tap.state)
        ST_CAP_DR: begin
          bsr_nxt   = (dr_sel(ir_r) == IR_EXTEST) ? cap_vec : bsr_r;
          id_sh_nxt = ID_WORD;
          bp_nxt    = 1'b0;
        end
        ST_SHIFT_DR: begin
          if (dr_sel(ir_r) == IR_EXTEST) begin
            bsr_nxt = {tdi_s, bsr_r[CHAIN_LEN-1:1]};
          end else if (dr_sel(ir_r) == IR_IDCODE) begin
            id_sh_nxt = {tdi_s, id_sh_r[ID_LEN-1:1]};
          end else begin
            bp_nxt = tdi_s;
          end
        end
        ST_UPD_DR: begin
          if (dr_sel(ir_r) == IR_EXTEST) begin
            upd_nxt = bsr_r;
          end
        end
        default: bp_nxt = bp_r;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      bsr_r   <= CHAIN_INIT;
      upd_r   <= CHAIN_INIT;
      id_sh_r <= ID_WORD;
      bp_r    <= 1'b0;
    end else begin
      bsr_r   <= bsr_nxt;
      upd_r   <= upd_nxt;
      id_sh_r <= id_sh_nxt;
      bp_r    <= bp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Serial output moves on the falling edge, giving the tester half a period
  // of settled data before its own rising-edge sample.
  assign in_shift = (tap.state == ST_SHIFT_DR) || (tap.state == ST_SHIFT_IR);
  always_comb begin
    case (dr_sel(ir_r))
      IR_EXTEST: dr_bit = bsr_r[0];
      IR_IDCODE: dr_bit = id_sh_r[0];
      default:   dr_bit = bp_r;
    endcase
    tdo_nxt = TDO;
    oe_nxt  = TDO_OE;
    if (tck_fall) begin
      tdo_nxt = (tap.state == ST_SHIFT_IR) ? ir_sh_r[0] : dr_bit;
      oe_nxt  = in_shift;
    end
    ext_nxt = (ir_r == IR_EXTEST);
    int_nxt = (ir_r == IR_INTEST);
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      TDO      <= 1'b0;
      TDO_OE   <= 1'b0;
      CELL_OUT <= CHAIN_INIT;
      EXT_MODE <= 1'b0;
      INT_MODE <= 1'b0;
    end else begin
      TDO      <= tdo_nxt;
      TDO_OE   <= oe_nxt;
      CELL_OUT <= upd_r;
      EXT_MODE <= ext_nxt;
      INT_MODE <= int_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence s_rise_in(bst_state_type st);
    tap.tck_rise && (tap.state == st);
  endsequence

  chk_ir_reset_id: assert property (@(posedge MCLK) disable iff (!RST_N)
    (tap.state == ST_RESET) |=> (ir_r == IR_IDCODE))
    else $error("Reset state did not load the identify code.");

  chk_ir_capture_code: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_rise_in(ST_CAP_IR) |=> (ir_sh_r == IR_CAPTURE))
    else $error("Instruction capture did not load 001.");

  chk_ir_shift_lsb: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_rise_in(ST_SHIFT_IR) |=> (ir_sh_r[2] == $past(tdi_s)) && (ir_sh_r[1:0] == $past(ir_sh_r[2:1])))
    else $error("Instruction shift direction wrong.");

  chk_bypass_one_stage: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_rise_in(ST_SHIFT_DR) ##0 (dr_sel(ir_r) == IR_BYPASS) |=> (bp_r == $past(tdi_s)))
    else $error("Bypass stage did not take the serial input.");

  chk_chain_shift: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_rise_in(ST_SHIFT_DR) ##0 (dr_sel(ir_r) == IR_EXTEST)
      |=> (bsr_r[CHAIN_LEN-1] == $past(tdi_s)) && (bsr_r[CHAIN_LEN-2:0] == $past(bsr_r[CHAIN_LEN-1:1])))
    else $error("Boundary chain did not shift by one cell.");

  chk_id_lsb_one: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_rise_in(ST_CAP_DR) ##0 (ir_r == IR_IDCODE) |=> (id_sh_r[0] == 1'b1) && (id_sh_r == ID_WORD))
    else $error("Identification word not captured with bit zero set.");

  chk_tdo_idle_off: assert property (@(posedge MCLK) disable iff (!RST_N)
    tck_fall && !in_shift |=> !TDO_OE)
    else $error("Serial output driven outside a shift state.");

  chk_update_drive: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_rise_in(ST_UPD_DR) ##0 (dr_sel(ir_r) == IR_EXTEST) ##1 !(tap.state == ST_RESET)
      |=> (CELL_OUT == $past(bsr_r, 2)))
    else $error("Update did not reach the cell outputs.");

  chk_ext_mode_out: assert property (@(posedge MCLK) disable iff (!RST_N)
    (ir_r == IR_EXTEST) |=> EXT_MODE && !INT_MODE)
    else $error("External mode flag not raised.");

endmodule
`default_nettype wire

/* File: dv/bst_tester.sv */
`timescale 1ns/100ps
`default_nettype none
// Board tester model. Each test clock phase lasts four system cycles, the least that the
// synchroniser and the falling-edge output allow, so the link clock runs at 80 ns.
module bst_tester (
  input  wire logic clk,
  input  wire logic tdo,
  input  wire logic tdo_oe,
  output var  logic tck,
  output var  logic tms,
  output var  logic tdi,
  output var  logic trst_n
);
  localparam int PHASE = 4;

  // The test clock rests low between frames; the test reset rests high except during pulse_trst.
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One test clock period; the output is read just before the rising edge.
  task automatic tick(input logic m, input logic d, output logic o, output logic oe);
    tms <= m;
    tdi <= d;
    repeat (PHASE) @(posedge clk);
    o = tdo;
    oe = tdo_oe;
    tck <= 1'b1;
    repeat (PHASE) @(posedge clk);
    tck <= 1'b0;
  endtask

  // Five high mode-select rises reach reset, one low rise then reaches idle.
  task automatic to_idle();
    logic o;
    logic oe;
    repeat (5) tick(1'b1, 1'b0, o, oe);
    tick(1'b0, 1'b0, o, oe);
  endtask

  // From idle, scans n bits through the instruction or data path and returns to idle.
  task automatic scan(input logic ir, input int n, input logic [157:0] din,
                      output logic [157:0] dout, output logic oe_ok);
    logic o;
    logic oe;
    tick(1'b1, 1'b0, o, oe);
    if (ir) tick(1'b1, 1'b0, o, oe);
    tick(1'b0, 1'b0, o, oe);
    tick(1'b0, 1'b0, o, oe);
    oe_ok = 1'b1;
    dout = '0;
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], o, oe);
      dout[i] = o;
      oe_ok = oe_ok & oe;
    end
    tick(1'b1, 1'b0, o, oe);
    tick(1'b0, 1'b0, o, oe);
  endtask

  // Pulses the test reset low for several system cycles.
  task automatic pulse_trst();
    trst_n <= 1'b0;
    repeat (8) @(posedge clk);
    trst_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* File: dv/bst_top_test.sv */
`timescale 1ns/100ps
`default_nettype none
module bst_top_test;
  import bst_pkg::*;
  localparam logic [3:0]  T_VER = 4'h3;     // Arbitrary value.
  localparam logic [15:0] T_DEV = 16'h5A3C; // Arbitrary value.
  localparam logic [10:0] T_MAK = 11'h2A6;  // Arbitrary value.
  logic         mclk;
  logic         rst_n;
  logic         tck;
  logic         tms;
  logic         tdi;
  logic         trst_n;
  logic         tdo;
  logic         tdo_oe;
  logic         ext_mode;
  logic         int_mode;
  logic         oe_ok;
  logic [157:0] pad_in;
  logic [157:0] core_in;
  logic [157:0] cell_out;
  logic [157:0] latch;
  logic [157:0] dout;
  int           n_errors;
  int           n_checks;
  int           cycles;

  bst_top #(.ID_VERSION(T_VER), .ID_DEVICE(T_DEV), .ID_MAKER(T_MAK)) i_bst_top (
    .MCLK(mclk), .RST_N(rst_n), .TCK(tck), .TMS(tms), .TDI(tdi), .TRST_N(trst_n),
    .PAD_IN(pad_in), .CORE_IN(core_in), .TDO(tdo), .TDO_OE(tdo_oe),
    .CELL_OUT(cell_out), .EXT_MODE(ext_mode), .INT_MODE(int_mode));

  bst_tester i_bst_tester (.clk(mclk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms),
    .tdi(tdi), .trst_n(trst_n));

  ////////////////////////////////////////////////////////////////////////////////
  // Compares one value and reports a mismatch at once.
  task automatic check(input string what, input logic [157:0] seen, input logic [157:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic conclude();
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Reads the identification code straight after the reset walk.
  task automatic t_idcode();
    i_bst_tester.to_idle();
    i_bst_tester.scan(1'b0, 32, 158'h0, dout, oe_ok);
    check("id code", dout[31:0], {T_VER, T_DEV, T_MAK, 1'b1});
    check("id oe", oe_ok, 1'b1);
    repeat (6) @(posedge mclk);
    check("oe idle", tdo_oe, 1'b0);
  endtask

  // Every bypass code, including unlisted ones, gives a one-stage delay.
  task automatic t_bypass();
    logic [2:0] codes [4] = '{3'h7, 3'h4, 3'h5, 3'h6};
    foreach (codes[k]) begin
      i_bst_tester.scan(1'b1, 3, {155'h0, codes[k]}, dout, oe_ok);
      check("ir capture", dout[2:0], IR_CAPTURE);
      i_bst_tester.scan(1'b0, 16, {142'h0, 16'hB38E}, dout, oe_ok);
      check("bypass", dout[15:1], 15'h338E);
    end
  endtask

  // Capture, exit and update of the instruction path without shifting select intest;
  // five high mode-select rises from idle then bring back the identify code.
  task automatic t_cap_ir();
    logic       o;
    logic       oe;
    logic [5:0] walk = 6'h1B;
    for (int i = 0; i < 6; i++) begin
      i_bst_tester.tick(walk[i], 1'b0, o, oe);
    end
    repeat (4) @(posedge mclk);
    check("intest flag", int_mode, 1'b1);
    i_bst_tester.to_idle();
    repeat (4) @(posedge mclk);
    check("tms reset", int_mode, 1'b0);
  endtask

  // Loads an instruction and scans one vector; the latch model follows each update.
  task automatic t_chain(input logic [2:0] code, input logic [157:0] v);
    logic [157:0] exp;
    i_bst_tester.scan(1'b1, 3, {155'h0, code}, dout, oe_ok);
    check("ir capture", dout[2:0], IR_CAPTURE);
    repeat (4) @(posedge mclk);
    check("extest flag", ext_mode, code == IR_EXTEST);
    check("intest flag", int_mode, code == IR_INTEST);
    for (int i = 0; i < 158; i++) begin
      exp[i] = IN_CELLS[i] ? (code == IR_INTEST ? latch[i] : pad_in[i]) : (code == IR_EXTEST ? latch[i] : core_in[i]);
    end
    i_bst_tester.scan(1'b0, 158, v, dout, oe_ok);
    check("chain out", dout, exp);
    check("chain oe", oe_ok, 1'b1);
    repeat (4) @(posedge mclk);
    check("cell out", cell_out, v);
    latch = v;
  endtask

  // Test reset mid-run restores cells, flags and the identify instruction.
  task automatic t_trst();
    logic o;
    logic oe;
    i_bst_tester.pulse_trst();
    check("trst cells", cell_out, CHAIN_INIT);
    check("trst ext", ext_mode, 1'b0);
    latch = CHAIN_INIT;
    i_bst_tester.tick(1'b0, 1'b0, o, oe);
    i_bst_tester.scan(1'b0, 32, 158'h0, dout, oe_ok);
    check("trst id", dout[31:0], {T_VER, T_DEV, T_MAK, 1'b1});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // System clock at 100 MHz.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Cuts a hang short; the whole run needs about 7300 cycles.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end

  // Main sequence.
  initial begin
    rst_n = 1'b0;
    pad_in = {79{2'h2}};
    core_in = {79{2'h1}};
    latch = CHAIN_INIT;
    n_errors = 0;
    n_checks = 0;
    cycles = 0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (6) @(posedge mclk);
    check("reset cells", cell_out, CHAIN_INIT);
    check("reset oe", tdo_oe, 1'b0);
    check("reset modes", {ext_mode, int_mode}, 2'h0);
    t_idcode();
    t_bypass();
    t_cap_ir();
    t_chain(IR_EXTEST, {79{2'h1}});
    pad_in <= ~pad_in;
    t_chain(IR_EXTEST, {2'h3, {39{4'h9}}});
    t_trst();
    t_chain(IR_SAMPLE, {2'h2, {39{4'hC}}});
    t_chain(IR_INTEST, {2'h1, {39{4'h6}}});
    conclude();
  end
endmodule
`default_nettype wire
